// ---- rtl/acs_map.svh ----
// register map, field positions, reset values and timing constants
// assumes inclusion by the converter control block, its result memory and the bench
//
// Overview of operation
// - target mask bit enables compare per input
// - writable ten bit high limit, resets zero
// - switch phase is (div[5:0]+3)*2 clocks
// - setup phase is (div+1)*2 clocks
// - conversion phase is (div[5:0]+1)*24 clocks
// - switch, setup, convert phases run in order
// - sixteen bit divider resets to all ones
// - one select bit per input, OR combines
// - select mask resets with all inputs selected
// - read-only ten bit result for inputs 0 to 2
// - compare flags outside or inside window
// - compare flag reads status, write one clears
// - start self clears, reads one while converting
// - zero to start stops continuous scan
`ifndef ACS_MAP_SVH
`define ACS_MAP_SVH
// ------------------------------------------------------------
// register byte offsets
// ------------------------------------------------------------
`define ACS_OFF_CTL 8'h00
`define ACS_OFF_TGT 8'h04
`define ACS_OFF_LO 8'h08
`define ACS_OFF_HI 8'h0C
`define ACS_OFF_DIV 8'h10
`define ACS_OFF_SEL 8'h14
`define ACS_OFF_RES0 8'h18
`define ACS_OFF_RES1 8'h1C
`define ACS_OFF_RES2 8'h20
`define ACS_OFF_IST 8'h24
`define ACS_OFF_IMSK 8'h28
// ------------------------------------------------------------
// control fields and status bits
// ------------------------------------------------------------
`define ACS_CTL_START 0
`define ACS_CTL_REPEAT 1
`define ACS_CTL_SCNFLG 3
`define ACS_CTL_SENSE 4
`define ACS_CTL_COMPARE_EVENT_FLAG 6
`define ACS_CTL_BUSY 7
`define ACS_IRQ_SCAN 0
`define ACS_IRQ_CMP 1
// ------------------------------------------------------------
// reset values and sizes
// ------------------------------------------------------------
`define ACS_DIV_RST 16'hFFFF
`define ACS_SEL_RST 6'h3F
`define ACS_NCH 6
// ------------------------------------------------------------
// phase timing terms in clock periods, clock period and minimum conversion time in ns
// ------------------------------------------------------------
`define ACS_SW_ADD 18'h3
`define ACS_SU_ADD 18'h1
`define ACS_CV_ADD 18'h1
`define ACS_CV_MUL 18'h18
`define ACS_CLK_NS 4
`define ACS_CONV_MIN_NS 6000
`define ACS_CONV_MIN_CYC ((`ACS_CONV_MIN_NS + `ACS_CLK_NS - 1) / `ACS_CLK_NS)
`endif

// ---- rtl/acs_pkg.sv ----
// types shared by the converter control block and its result memory
// assumes nothing beyond a single clock domain
package acs_pkg;
    // scan phases, gray coded along idle-switch-setup-convert
    typedef enum logic [1:0] {
        ACS_IDLE = 2'h0,
        ACS_SWITCH = 2'h1,
        ACS_SETUP = 2'h3,
        ACS_CONVERT = 2'h2
    } acs_state_type;
    // all state of the control block
    typedef struct packed {
        acs_state_type state;
        logic [2:0] chan;
        logic [17:0] cnt;
        logic start;
        logic repeat_md;
        logic sense;
        logic [5:0] tgt;
        logic [5:0] sel;
        logic [9:0] lo;
        logic [9:0] hi;
        logic [15:0] div;
        logic [1:0] irq_st;
        logic [1:0] irq_mask;
        logic [31:0] rd;
        logic rd_mem;
    } acs_regs_type;
    // all state of the result memory
    typedef struct packed {
        logic [5:0][9:0] word;
        logic [9:0] q;
    } acs_mem_type;
endpackage : acs_pkg

// ---- rtl/acs_result_mem.sv ----
// per-input conversion results with one write and one registered read
// assumes the caller keeps addresses below the input count
`timescale 1ns/1ps
`include "acs_map.svh"
module acs_result_mem (
    // clock and reset
    input wire logic clock_in,
    input wire logic reset_in,
    // write side
    input wire logic wr_en_in,
    input wire logic [2:0] wr_addr_in,
    input wire logic [9:0] wr_data_in,
    // read side
    input wire logic [2:0] rd_addr_in,
    output logic [9:0] rd_data_out
);
    import acs_pkg::*;
    acs_mem_type mem_ff; // stored words and read register
    acs_mem_type nxt_mem; // next value
    // write the addressed word, read out after one clock
    always_comb
    begin
        nxt_mem = mem_ff;
        for (int i = 0; i < `ACS_NCH; i++)
        begin
            if (wr_en_in && wr_addr_in == 3'(i))
            begin
                nxt_mem.word[i] = wr_data_in;
            end
        end
        nxt_mem.q = '0;
        if (rd_addr_in < 3'(`ACS_NCH))
        begin
            nxt_mem.q = mem_ff.word[rd_addr_in];
        end
    end
    // results read as zero after reset
    always_ff @(posedge clock_in)
    begin
        if (reset_in)
            mem_ff <= '0;
        else
            mem_ff <= nxt_mem;
    end
    assign rd_data_out = mem_ff.q;
endmodule : acs_result_mem

// ---- rtl/acs_control.sv ----
// scan sequencer, window comparator and register file of the converter
// assumes a converter whose data is valid at the end of convert phase
`timescale 1ns/1ps
`include "acs_map.svh"
module acs_control (
    // clock and reset
    input wire logic clock_in,
    input wire logic reset_in,
    // register port
    input wire logic [7:0] addr_in,
    input wire logic [31:0] wr_data_in,
    input wire logic wr_in,
    input wire logic rd_in,
    output logic [31:0] rd_data_out,
    // converter side
    input wire logic [9:0] adc_data_in,
    output logic [2:0] adc_chan_out,
    output acs_pkg::acs_state_type adc_phase_out,
    // interrupt
    output logic irq_out
);
    import acs_pkg::*;

    // ------------------------------------------------------------
    // state and decode
    // ------------------------------------------------------------
    acs_regs_type st_ff; // registered state
    acs_regs_type nxt_st; // next state
    logic [9:0] res_q; // result memory read data
    logic res_we; // result store strobe
    logic [7:0] res_off; // offset within the result block
    logic [17:0] sw_len; // switch phase length
    logic [17:0] su_len; // setup phase length
    logic [17:0] cv_len; // convert phase length
    logic [3:0] first_ch; // first selected input, found flag on top
    logic [3:0] next_ch; // next selected input after current
    logic conv_end; // last cycle of a conversion
    logic in_win; // sample inside the window
    logic cmp_hit; // comparator event this cycle
    logic [1:0] irq_clr; // status bits cleared by software
    logic [1:0] irq_set; // status bits raised by hardware
    logic go; // scan start request accepted
    logic halt; // continuous scan stopped by software

    // lowest set mask bit at or above a given input
    function automatic logic [3:0] pick_from(
        input logic [5:0] m,
        input logic [3:0] from
    );
        logic [3:0] r;
        r = '0;
        for (int i = `ACS_NCH - 1; i >= 0; i--)
        begin
            if (m[i] && 4'(i) >= from)
                r = {1'b1, 3'(i)};
        end
        return r;
    endfunction : pick_from

    // ------------------------------------------------------------
    // phase lengths, taken from the divider at phase entry
    // ------------------------------------------------------------
    assign sw_len = 18'((18'(st_ff.div[5:0]) + `ACS_SW_ADD) << 1);
    assign su_len = 18'((18'(st_ff.div) + `ACS_SU_ADD) << 1);
    assign cv_len = 18'((18'(st_ff.div[5:0]) + `ACS_CV_ADD) * `ACS_CV_MUL);

    // ------------------------------------------------------------
    // channel walk and comparator
    // ------------------------------------------------------------
    assign first_ch = pick_from(st_ff.sel, 4'h0);
    assign next_ch = pick_from(st_ff.sel, 4'(st_ff.chan) + 4'h1);
    assign conv_end = st_ff.state == ACS_CONVERT && st_ff.cnt == '0;
    assign res_we = conv_end;
    assign in_win = adc_data_in >= st_ff.lo && adc_data_in <= st_ff.hi;
    // sense 0 flags outside the window, 1 flags inside
    assign cmp_hit = conv_end && st_ff.tgt[st_ff.chan]
        && (st_ff.sense ? in_win : !in_win);
    assign res_off = addr_in - `ACS_OFF_RES0;

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_st = st_ff;
        nxt_st.rd = '0;
        nxt_st.rd_mem = 1'b0;
        irq_clr = '0;
        go = 1'b0;
        halt = 1'b0;
        // register writes; reserved bits are dropped
        if (wr_in)
        begin
            unique case (addr_in)
                `ACS_OFF_CTL:
                begin
                    nxt_st.repeat_md = wr_data_in[`ACS_CTL_REPEAT];
                    nxt_st.sense = wr_data_in[`ACS_CTL_SENSE];
                    irq_clr[`ACS_IRQ_CMP] = wr_data_in[`ACS_CTL_COMPARE_EVENT_FLAG];
                    irq_clr[`ACS_IRQ_SCAN] = wr_data_in[`ACS_CTL_SCNFLG];
                    // an empty mask never starts, start stays zero
                    go = wr_data_in[`ACS_CTL_START] && first_ch[3]
                        && st_ff.state == ACS_IDLE;
                    halt = !wr_data_in[`ACS_CTL_START] && st_ff.repeat_md
                        && st_ff.state != ACS_IDLE;
                end
                `ACS_OFF_TGT: nxt_st.tgt = wr_data_in[5:0];
                `ACS_OFF_LO: nxt_st.lo = wr_data_in[9:0];
                `ACS_OFF_HI: nxt_st.hi = wr_data_in[9:0];
                `ACS_OFF_DIV: nxt_st.div = wr_data_in[15:0];
                `ACS_OFF_SEL: nxt_st.sel = wr_data_in[5:0];
                `ACS_OFF_IST: irq_clr = wr_data_in[1:0];
                `ACS_OFF_IMSK: nxt_st.irq_mask = wr_data_in[1:0];
                // unmapped and read-only offsets ignore writes
                default: ;
            endcase
        end
        // register reads, answered one clock later
        if (rd_in)
        begin
            unique case (addr_in)
                `ACS_OFF_CTL:
                begin
                    nxt_st.rd[`ACS_CTL_START] = st_ff.start;
                    nxt_st.rd[`ACS_CTL_REPEAT] = st_ff.repeat_md;
                    nxt_st.rd[`ACS_CTL_SCNFLG] = st_ff.irq_st[`ACS_IRQ_SCAN];
                    nxt_st.rd[`ACS_CTL_SENSE] = st_ff.sense;
                    nxt_st.rd[`ACS_CTL_COMPARE_EVENT_FLAG] = st_ff.irq_st[`ACS_IRQ_CMP];
                    nxt_st.rd[`ACS_CTL_BUSY] = st_ff.state != ACS_IDLE;
                end
                `ACS_OFF_TGT: nxt_st.rd[5:0] = st_ff.tgt;
                `ACS_OFF_LO: nxt_st.rd[9:0] = st_ff.lo;
                `ACS_OFF_HI: nxt_st.rd[9:0] = st_ff.hi;
                `ACS_OFF_DIV: nxt_st.rd[15:0] = st_ff.div;
                `ACS_OFF_SEL: nxt_st.rd[5:0] = st_ff.sel;
                `ACS_OFF_RES0, `ACS_OFF_RES1, `ACS_OFF_RES2:
                    nxt_st.rd_mem = 1'b1;
                `ACS_OFF_IST: nxt_st.rd[1:0] = st_ff.irq_st;
                `ACS_OFF_IMSK: nxt_st.rd[1:0] = st_ff.irq_mask;
                // unmapped offsets read zero
                default: ;
            endcase
        end
        irq_set = '0;
        irq_set[`ACS_IRQ_CMP] = cmp_hit;
        // scan sequencer
        if (halt)
        begin
            // abandon the sample in flight; one whose convert phase ends this cycle is still stored
            nxt_st.state = ACS_IDLE;
            nxt_st.start = 1'b0;
        end
        else
        begin
            unique case (st_ff.state)
                ACS_IDLE:
                begin
                    if (go)
                    begin
                        nxt_st.state = ACS_SWITCH;
                        nxt_st.chan = first_ch[2:0];
                        nxt_st.cnt = sw_len - 18'h1;
                        nxt_st.start = 1'b1;
                    end
                end
                ACS_SWITCH:
                begin
                    if (st_ff.cnt == '0)
                    begin
                        nxt_st.state = ACS_SETUP;
                        nxt_st.cnt = su_len - 18'h1;
                    end
                    else
                        nxt_st.cnt = st_ff.cnt - 18'h1;
                end
                ACS_SETUP:
                begin
                    if (st_ff.cnt == '0)
                    begin
                        nxt_st.state = ACS_CONVERT;
                        nxt_st.cnt = cv_len - 18'h1;
                    end
                    else
                        nxt_st.cnt = st_ff.cnt - 18'h1;
                end
                ACS_CONVERT:
                begin
                    if (st_ff.cnt != '0)
                        nxt_st.cnt = st_ff.cnt - 18'h1;
                    else if (next_ch[3])
                    begin
                        // more inputs in this pass
                        nxt_st.state = ACS_SWITCH;
                        nxt_st.chan = next_ch[2:0];
                        nxt_st.cnt = sw_len - 18'h1;
                    end
                    else
                    begin
                        irq_set[`ACS_IRQ_SCAN] = 1'b1;
                        if (st_ff.repeat_md && first_ch[3])
                        begin
                            nxt_st.state = ACS_SWITCH;
                            nxt_st.chan = first_ch[2:0];
                            nxt_st.cnt = sw_len - 18'h1;
                        end
                        else
                        begin
                            nxt_st.state = ACS_IDLE;
                            nxt_st.start = 1'b0;
                        end
                    end
                end
            endcase
        end
        // a new event wins over a clear in the same cycle
        nxt_st.irq_st = (st_ff.irq_st & ~irq_clr) | irq_set;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            st_ff <= '0;
            st_ff.div <= `ACS_DIV_RST;
            st_ff.sel <= `ACS_SEL_RST;
        end
        else
            st_ff <= nxt_st;
    end

    // ------------------------------------------------------------
    // result storage
    // ------------------------------------------------------------
    acs_result_mem u_results (
        .clock_in(clock_in),
        .reset_in(reset_in),
        .wr_en_in(res_we),
        .wr_addr_in(st_ff.chan),
        .wr_data_in(adc_data_in),
        .rd_addr_in(res_off[4:2]),
        .rd_data_out(res_q)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    // both sources are registers, so read data stands one clock
    assign rd_data_out = st_ff.rd_mem ? 32'(res_q) : st_ff.rd;
    assign adc_chan_out = st_ff.chan;
    assign adc_phase_out = st_ff.state;
    assign irq_out = |(st_ff.irq_st & st_ff.irq_mask);

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (reset_in);

    // cycles spent in the current phase, and its expected length
    logic [17:0] ph_cnt_q;
    logic [17:0] exp_q;
    always_ff @(posedge clock_in)
    begin
        if (reset_in || st_ff.state != nxt_st.state
            || (conv_end && !halt))
            ph_cnt_q <= '0;
        else
            ph_cnt_q <= ph_cnt_q + 18'h1;
        if (reset_in)
            exp_q <= '0;
        else if (nxt_st.state == ACS_SWITCH && nxt_st.cnt == sw_len - 18'h1)
            exp_q <= sw_len;
        else if (st_ff.state == ACS_SWITCH && nxt_st.state == ACS_SETUP)
            exp_q <= su_len;
        else if (st_ff.state == ACS_SETUP && nxt_st.state == ACS_CONVERT)
            exp_q <= cv_len;
    end

    switch_len_a: assert property (
        st_ff.state == ACS_SWITCH && nxt_st.state == ACS_SETUP
        |-> ph_cnt_q + 18'h1 == exp_q)
        else $error("switch phase length wrong");
    setup_len_a: assert property (
        st_ff.state == ACS_SETUP && nxt_st.state == ACS_CONVERT
        |-> ph_cnt_q + 18'h1 == exp_q)
        else $error("setup phase length wrong");
    conv_len_a: assert property (
        conv_end |-> ph_cnt_q + 18'h1 == exp_q)
        else $error("convert phase length wrong");
    phase_order_a: assert property (
        st_ff.state == ACS_SWITCH ##1 st_ff.state != ACS_SWITCH
        |-> st_ff.state inside {ACS_SETUP, ACS_IDLE})
        else $error("phase left out of order");
    reset_values_a: assert property (
        $past(reset_in) |-> st_ff.div == `ACS_DIV_RST
        && st_ff.sel == `ACS_SEL_RST && st_ff.hi == '0)
        else $error("reset value wrong");
    store_selected_a: assert property (
        res_we |-> st_ff.sel[st_ff.chan] || $past(wr_in))
        else $error("unselected input stored");
    cmp_flag_a: assert property (
        cmp_hit |=> st_ff.irq_st[`ACS_IRQ_CMP])
        else $error("compare event lost");
    cmp_clear_a: assert property (
        wr_in && addr_in == `ACS_OFF_CTL && wr_data_in[`ACS_CTL_COMPARE_EVENT_FLAG]
        && !cmp_hit |=> !st_ff.irq_st[`ACS_IRQ_CMP])
        else $error("compare flag not cleared");
    start_busy_a: assert property (
        st_ff.start == (st_ff.state != ACS_IDLE))
        else $error("start bit not tracking scan");
    stop_scan_a: assert property (
        halt |=> st_ff.state == ACS_IDLE ##1 st_ff.state == ACS_IDLE
        || $past(go))
        else $error("continuous scan not stopped");
    high_write_a: assert property (
        wr_in && addr_in == `ACS_OFF_HI
        |=> st_ff.hi == $past(wr_data_in[9:0]))
        else $error("high limit not written");
    setup_next_a: assert property (
        st_ff.state == ACS_SETUP ##1 st_ff.state != ACS_SETUP
        |-> st_ff.state inside {ACS_CONVERT, ACS_IDLE})
        else $error("setup phase left out of order");
    convert_next_a: assert property (
        st_ff.state == ACS_CONVERT ##1 st_ff.state != ACS_CONVERT
        |-> st_ff.state inside {ACS_SWITCH, ACS_IDLE})
        else $error("convert phase left out of order");
    read_idle_a: assert property (
        !$past(rd_in) |-> rd_data_out == '0)
        else $error("read data outside read slot");
    chan_hold_a: assert property (
        st_ff.state != ACS_SWITCH ##1 st_ff.state != ACS_SWITCH
        |-> $stable(adc_chan_out))
        else $error("input changed outside switch phase");

    pass_end_c: cover property (irq_set[`ACS_IRQ_SCAN]);
    cmp_event_c: cover property (cmp_hit && st_ff.sense);
    repeat_c: cover property (halt);
    set_clear_c: cover property (cmp_hit && irq_clr[`ACS_IRQ_CMP]);
endmodule : acs_control

// ---- bench/acs_adc_model.sv ----
// behavioural analog multiplexer and conversion core for the bench
// assumes the sequencer samples on the last convert-phase cycle
`timescale 1ns/1ps
module acs_adc_model (
    // clock
    input wire logic clock_in,
    // sequencer side
    input wire logic [2:0] chan_in,
    input wire acs_pkg::acs_state_type phase_in,
    // analog level set by the bench
    input wire logic [9:0] level_in,
    // converter output
    output logic [9:0] sample_out
);
    import acs_pkg::*;
    // ------------------------------------------------------------
    // sample path
    // ------------------------------------------------------------
    logic [9:0] junk_ff = 10'h2AA; // changes every cycle
    // junk outside conversion, so a wrong sample point cannot pass
    always_ff @(posedge clock_in)
    begin
        junk_ff <= ~junk_ff ^ 10'h155;
    end
    // each input reads a little higher, so a wrong input shows up
    always_comb
    begin
        if (phase_in == ACS_CONVERT)
            sample_out = level_in + {7'h0, chan_in};
        else
            sample_out = junk_ff;
    end
endmodule : acs_adc_model

// ---- bench/test_adc_scan_compare_control.sv ----
// self-checking bench for the converter control block
// assumes the control block, its package, map header and the model
`timescale 1ns/1ps
`include "acs_map.svh"
module test_adc_scan_compare_control;
    import acs_pkg::*;
    // ------------------------------------------------------------
    // signals and bookkeeping
    // ------------------------------------------------------------
    logic clock_in;
    logic reset_in;
    logic [7:0] addr_in;
    logic [31:0] wr_data_in;
    logic wr_in;
    logic rd_in;
    logic [31:0] rd_data_out;
    logic [9:0] adc_data_in;
    logic [2:0] adc_chan_out;
    acs_state_type adc_phase_out;
    logic irq_out;
    logic [9:0] level; // analog level fed to the model
    int num_errors;
    int n_tests;
    int cnt; // cycles spent in the current phase
    int len [4]; // last length of each phase
    logic [2:0] chan_q [$]; // inputs in conversion order
    acs_state_type prev;
    logic [31:0] rv;
    logic [7:0] offs [11] = '{`ACS_OFF_CTL, `ACS_OFF_TGT, `ACS_OFF_LO,
        `ACS_OFF_HI, `ACS_OFF_DIV, `ACS_OFF_SEL, `ACS_OFF_RES0,
        `ACS_OFF_RES1, `ACS_OFF_RES2, `ACS_OFF_IMSK, 8'h2C};
    logic [31:0] rst_v [11] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'hFFFF,
        32'h3F, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
    logic [9:0] lv [4] = '{10'h0FF, 10'h100, 10'h200, 10'h201};
    logic outside [4] = '{1'b1, 1'b0, 1'b0, 1'b1};
    acs_control acs_control_inst (.clock_in(clock_in), .reset_in(reset_in),
        .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in),
        .rd_in(rd_in), .rd_data_out(rd_data_out),
        .adc_data_in(adc_data_in), .adc_chan_out(adc_chan_out),
        .adc_phase_out(adc_phase_out), .irq_out(irq_out));
    acs_adc_model acs_adc_model_inst (.clock_in(clock_in),
        .chan_in(adc_chan_out), .phase_in(adc_phase_out),
        .level_in(level), .sample_out(adc_data_in));
    // ------------------------------------------------------------
    // clock, phase monitor, watchdog
    // ------------------------------------------------------------
    initial
    begin
        clock_in = 1'b0;
        forever #2 clock_in = ~clock_in;
    end
    // phase lengths and input order seen at the converter pins
    always @(posedge clock_in)
    begin
        if (adc_phase_out !== prev)
        begin
            len[prev] = cnt;
            cnt = 0;
            if (adc_phase_out === ACS_CONVERT)
                chan_q.push_back(adc_chan_out);
        end
        prev = adc_phase_out;
        cnt = cnt + 1;
    end
    // about twice the expected run of some 28000 clocks
    initial
    begin
        #240000;
        num_errors++;
        $display("ERROR at %0t: watchdog expired", $time);
        stop_test();
    end
    // ------------------------------------------------------------
    // register port tasks and compares
    // ------------------------------------------------------------
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock_in);
        addr_in <= a;
        wr_data_in <= d;
        wr_in <= 1'b1;
        @(posedge clock_in);
        wr_in <= 1'b0;
    endtask : wr
    // data stand only in the cycle after the strobe
    task rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge clock_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge clock_in);
        rd_in <= 1'b0;
        #1 d = rd_data_out;
    endtask : rd
    task chk_val(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("ERROR at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_val
    task chk_reg(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        chk_val(d, exp);
    endtask : chk_reg
    // start a scan and wait, bounded, for the sequencer to go idle
    task run_scan(input logic [5:0] sel, input logic [31:0] ctl);
        int i;
        wr(`ACS_OFF_SEL, {26'h0, sel});
        chan_q.delete();
        wr(`ACS_OFF_CTL, ctl);
        i = 0;
        repeat (2) @(posedge clock_in);
        while (adc_phase_out !== ACS_IDLE && i < 8000)
        begin
            @(posedge clock_in);
            #1 i++;
        end
        // the phase monitor books the last length one edge later
        @(posedge clock_in);
        #1 chk_val(i < 8000, 1'b1);
    endtask : run_scan
    task stop_test;
        $display("errors %0d, checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : stop_test
    // ------------------------------------------------------------
    // test sequence
    // ------------------------------------------------------------
    initial
    begin
        reset_in = 1'b1;
        addr_in = 8'h0;
        wr_data_in = 32'h0;
        wr_in = 1'b0;
        rd_in = 1'b0;
        level = 10'h050;
        prev = ACS_IDLE;
        cnt = 0;
        repeat (3) @(posedge clock_in);
        reset_in <= 1'b0;
        // reset values, unmapped place last
        foreach (offs[i]) chk_reg(offs[i], rst_v[i]);
        wr(`ACS_OFF_LO, 32'h100);
        wr(`ACS_OFF_HI, 32'h200);
        wr(`ACS_OFF_TGT, 32'h1);
        // longest convert divider, conversion just above six microseconds
        wr(`ACS_OFF_DIV, 32'h3F);
        wr(`ACS_OFF_RES0, 32'h3FF);
        chk_reg(`ACS_OFF_HI, 32'h200);
        chk_reg(`ACS_OFF_TGT, 32'h1);
        chk_reg(`ACS_OFF_RES0, 32'h0);
        // one-shot over inputs 0 and 2, only input 0 compared
        wr(`ACS_OFF_IMSK, 32'h3);
        wr(`ACS_OFF_SEL, 32'h05);
        wr(`ACS_OFF_CTL, 32'h1);
        chk_reg(`ACS_OFF_CTL, 32'h81);
        run_scan(6'h05, 32'h0);
        chk_val(chan_q.size(), 2);
        chk_val(chan_q[0], 3'h0);
        chk_val(chan_q[1], 3'h2);
        chk_val(len[ACS_SWITCH], 132);
        chk_val(len[ACS_SETUP], 128);
        chk_val(len[ACS_CONVERT], 1536);
        chk_val(len[ACS_CONVERT] >= `ACS_CONV_MIN_CYC, 1'b1);
        chk_reg(`ACS_OFF_RES0, 32'h050);
        chk_reg(`ACS_OFF_RES1, 32'h0);
        chk_reg(`ACS_OFF_RES2, 32'h052);
        chk_reg(`ACS_OFF_CTL, 32'h48);
        chk_val(irq_out, 1'b1);
        wr(`ACS_OFF_CTL, 32'h48);
        chk_reg(`ACS_OFF_IST, 32'h0);
        chk_val(irq_out, 1'b0);
        // masked events keep the line low until unmasked
        wr(`ACS_OFF_IMSK, 32'h0);
        run_scan(6'h01, 32'h1);
        chk_val(irq_out, 1'b0);
        wr(`ACS_OFF_IMSK, 32'h2);
        @(posedge clock_in);
        #1 chk_val(irq_out, 1'b1);
        wr(`ACS_OFF_IST, 32'h3);
        chk_reg(`ACS_OFF_CTL, 32'h0);
        // window edges in both senses on input 1
        wr(`ACS_OFF_TGT, 32'h2);
        for (int s = 0; s < 2; s++)
        begin
            for (int k = 0; k < 4; k++)
            begin
                level = lv[k] - 10'h1;
                run_scan(6'h02, 32'h1 | (s << 4));
                chk_reg(`ACS_OFF_RES1, {22'h0, lv[k]});
                rd(`ACS_OFF_CTL, rv);
                chk_val(rv[6], outside[k] ^ s[0]);
                wr(`ACS_OFF_CTL, 32'h48);
            end
        end
        // not a target: no event even when outside
        wr(`ACS_OFF_TGT, 32'h1);
        run_scan(6'h02, 32'h1);
        chk_reg(`ACS_OFF_IST, 32'h1);
        wr(`ACS_OFF_IST, 32'h3);
        // upper divider bits stretch only the setup phase
        wr(`ACS_OFF_DIV, 32'h013F);
        run_scan(6'h01, 32'h1);
        chk_val(len[ACS_SWITCH], 132);
        chk_val(len[ACS_SETUP], 640);
        chk_val(len[ACS_CONVERT], 1536);
        wr(`ACS_OFF_DIV, 32'h3F);
        // continuous scan, then stopped by a zero start bit
        chan_q.delete();
        wr(`ACS_OFF_CTL, 32'h3);
        for (int i = 0; i < 8000 && chan_q.size() < 3; i++)
            @(posedge clock_in);
        chk_val(chan_q.size() >= 3, 1'b1);
        wr(`ACS_OFF_CTL, 32'h2);
        #1 chk_val(adc_phase_out, ACS_IDLE);
        rd(`ACS_OFF_CTL, rv);
        chk_val(rv[0], 1'b0);
        stop_test();
    end
endmodule : test_adc_scan_compare_control
